// >>> rtl/msst_exec.sv
// Function
// - working minus operand minus inverted carry
// - carry clear if negative, else set
// - borrow subtract result written to memory
// - plain subtract ignores carry, any destination
// - decrement memory, skip when zero
// - decrement into working, memory unchanged, skip
// - increment memory or working, skip when zero
// - every skip-class instruction takes two cycles
// - byte set all ones, bit set one bit
// - bit test skips on nonzero or zero
// - byte test rewrites byte, skips per form
// - copy byte to working, skip when zero
// - nibble swap to memory or working
// - page read: low to memory, high to result
// - last page read uses index low only
// - preincrement index low before table read
// - xor to working or memory, zero flag only
`timescale 1ns/1ps
module msst_exec
   import msst_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [DATA_W-1:0] dmem [0:(1<<DM_AW)-1];
   logic [PM_W-1:0]   pmem [0:(1<<PM_AW)-1];
   logic [DATA_W-1:0] work;
   logic [FLAG_W-1:0] flags;
   logic [DATA_W-1:0] tbl_low;
   logic [DATA_W-1:0] tbl_high;
   logic [DATA_W-1:0] tbl_res;
   logic [PM_AW-1:0]  pc;
   logic [DM_AW-1:0]  dm_ptr;
   logic [PM_AW-1:0]  pm_ptr;
   logic [STAT_W-1:0] stat;
   logic              dummy;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire access   = psel & penable & ~pready;
   wire wr       = access & pwrite;
   wire hit_cmd  = (paddr == OFS_CMD);
   wire hit_work = (paddr == OFS_WORK);
   wire hit_flag = (paddr == OFS_FLAGS);
   wire hit_tlow = (paddr == OFS_TLOW);
   wire hit_thi  = (paddr == OFS_THIGH);
   wire hit_tres = (paddr == OFS_TRES);
   wire hit_pc   = (paddr == OFS_PC);
   wire hit_dadr = (paddr == OFS_DADDR);
   wire hit_ddat = (paddr == OFS_DDATA);
   wire hit_padr = (paddr == OFS_PADDR);
   wire hit_pdat = (paddr == OFS_PDATA);
   wire hit_stat = (paddr == OFS_STAT);
   wire mapped   = hit_cmd | hit_work | hit_flag | hit_tlow | hit_thi
                 | hit_tres | hit_pc | hit_dadr | hit_ddat | hit_padr
                 | hit_pdat | hit_stat;
   wire exec_go  = wr & hit_cmd & ~dummy;

   ////////////////////////////////////////////////////////////////////////////
   // command fields
   wire logic [OP_W-1:0]   op_raw  = pwdata[CMD_OP_LSB +: OP_W];
   wire msst_op_t          op      = msst_op_t'(op_raw);
   wire logic [BIT_W-1:0]  bit_idx = pwdata[CMD_BIT_LSB +: BIT_W];
   wire logic [DM_AW-1:0]  m_addr  = pwdata[CMD_ADDR_LSB +: DM_AW];
   wire logic [DATA_W-1:0] imm     = pwdata[CMD_IMM_LSB +: DATA_W];
   wire logic [DATA_W-1:0] mem_rd  = dmem[m_addr];
   wire logic              mem_bit = mem_rd[bit_idx];
   wire logic [DATA_W-1:0] mem_inc = mem_rd + BYTE_ONE;
   wire logic [DATA_W-1:0] mem_dec = mem_rd - BYTE_ONE;
   wire logic [DATA_W-1:0] swapped =
      {mem_rd[DATA_W/2-1:0], mem_rd[DATA_W-1:DATA_W/2]};

   ////////////////////////////////////////////////////////////////////////////
   // subtraction operand selection
   wire imm_form   = (op == OP_MINUS_BORROW_IMM) | (op == OP_MINUS_IMM);
   wire borrow_frm = (op == OP_MINUS_BORROW_MEM) | (op == OP_MINUS_BORROW_IMM)
                   | (op == OP_MINUS_BORROW_TO_MEMORY);
   wire logic [DATA_W-1:0] sub_b   = imm_form ? imm : mem_rd;
   // borrow forms take carry in, plain forms a fixed one
   wire logic              sub_cin = borrow_frm ? flags[F_CARRY] : 1'b1;
   wire logic [FLAG_W+DATA_W-1:0] sub_out =
      msst_sub(work, sub_b, sub_cin, flags[F_CZERO], borrow_frm);
   wire logic [DATA_W-1:0] sub_res = sub_out[DATA_W-1:0];
   wire logic [FLAG_W-1:0] sub_flg = sub_out[FLAG_W+DATA_W-1:DATA_W];
   wire logic [DATA_W-1:0] xor_b   = (op == OP_XOR_IMM) ? imm : mem_rd;
   wire logic [DATA_W-1:0] xor_res = work ^ xor_b;

   ////////////////////////////////////////////////////////////////////////////
   // table address
   wire preinc    = (op == OP_PREINCREMENT_TABLE_READ)
                  | (op == OP_PREINCREMENT_LAST_PAGE_READ);
   wire last_pg   = (op == OP_LAST_PAGE_TABLE_READ)
                  | (op == OP_PREINCREMENT_LAST_PAGE_READ);
   wire logic [DATA_W-1:0]    tlow_inc = tbl_low + BYTE_ONE;
   wire logic [DATA_W-1:0]    tlow_use = preinc ? tlow_inc : tbl_low;
   wire logic [PAGE_BITS-1:0] page     =
      last_pg ? LAST_PAGE : tbl_high[PAGE_BITS-1:0];
   wire logic [PM_W-1:0]      pm_word  = pmem[{page, tlow_use}];

   ////////////////////////////////////////////////////////////////////////////
   // execute
   logic [DATA_W-1:0] next_work;
   logic [FLAG_W-1:0] next_flags;
   logic [DATA_W-1:0] next_tbl_low;
   logic [DATA_W-1:0] dm_wdata;
   logic              dm_we;
   logic              tres_we;
   logic              skip;
   logic              skip_cls;
   logic              bad_op;

   always_comb
   begin
      next_work    = work;
      next_flags   = flags;
      next_tbl_low = tbl_low;
      dm_wdata     = mem_rd;
      dm_we        = 1'b0;
      tres_we      = 1'b0;
      skip         = 1'b0;
      skip_cls     = 1'b0;
      bad_op       = 1'b0;
      unique case (op)
         OP_NOP: ;
         OP_MINUS_BORROW_MEM, OP_MINUS_BORROW_IMM, OP_MINUS_MEM,
         OP_MINUS_IMM:
         begin
            next_work  = sub_res;
            next_flags = sub_flg;
         end
         OP_MINUS_BORROW_TO_MEMORY, OP_MINUS_TO_MEMORY:
         begin
            dm_wdata   = sub_res;
            dm_we      = 1'b1;
            next_flags = sub_flg;
         end
         OP_DECREMENT_SKIP_ON_ZERO:
         begin
            dm_wdata = mem_dec;
            dm_we    = 1'b1;
            skip_cls = 1'b1;
            skip     = (mem_dec == BYTE_RST);
         end
         OP_DECREMENT_SKIP_TO_WORKING:
         begin
            next_work = mem_dec;
            skip_cls  = 1'b1;
            skip      = (mem_dec == BYTE_RST);
         end
         OP_INCREMENT_SKIP_ON_ZERO:
         begin
            dm_wdata = mem_inc;
            dm_we    = 1'b1;
            skip_cls = 1'b1;
            skip     = (mem_inc == BYTE_RST);
         end
         OP_INCREMENT_SKIP_TO_WORKING:
         begin
            next_work = mem_inc;
            skip_cls  = 1'b1;
            skip      = (mem_inc == BYTE_RST);
         end
         OP_SET_BYTE:
         begin
            dm_wdata = BYTE_ONES;
            dm_we    = 1'b1;
         end
         OP_SET_BIT:
         begin
            dm_wdata = mem_rd | (BYTE_ONE << bit_idx);
            dm_we    = 1'b1;
         end
         OP_SKIP_IF_NONZERO_BIT:
         begin
            skip_cls = 1'b1;
            skip     = mem_bit;
         end
         OP_SKIP_IF_ZERO_BIT:
         begin
            skip_cls = 1'b1;
            skip     = ~mem_bit;
         end
         OP_SKIP_IF_NONZERO:
         begin
            dm_we    = 1'b1;
            skip_cls = 1'b1;
            skip     = (mem_rd != BYTE_RST);
         end
         OP_SKIP_IF_ZERO:
         begin
            dm_we    = 1'b1;
            skip_cls = 1'b1;
            skip     = (mem_rd == BYTE_RST);
         end
         OP_COPY_AND_SKIP_ZERO:
         begin
            next_work = mem_rd;
            skip_cls  = 1'b1;
            skip      = (mem_rd == BYTE_RST);
         end
         OP_NIBBLE_EXCHANGE:
         begin
            dm_wdata = swapped;
            dm_we    = 1'b1;
         end
         OP_NIBBLE_EXCHANGE_TO_WORKING:
            next_work = swapped;
         OP_PAGE_TABLE_READ, OP_LAST_PAGE_TABLE_READ,
         OP_PREINCREMENT_TABLE_READ, OP_PREINCREMENT_LAST_PAGE_READ:
         begin
            next_tbl_low = tlow_use;
            dm_wdata     = pm_word[DATA_W-1:0];
            dm_we        = 1'b1;
            tres_we      = 1'b1;
         end
         OP_XOR_MEM, OP_XOR_IMM:
         begin
            next_work          = xor_res;
            next_flags[F_ZERO] = (xor_res == BYTE_RST);
         end
         OP_EXCLUSIVE_OR_TO_MEMORY:
         begin
            dm_wdata           = xor_res;
            dm_we              = 1'b1;
            next_flags[F_ZERO] = (xor_res == BYTE_RST);
         end
         default:
            bad_op = 1'b1;
      endcase
   end

   // skip-class holds the access one extra dummy cycle
   wire logic             hold    = exec_go & skip_cls;
   wire logic [PM_AW-1:0] pc_step = skip ? PC_SKIP : PC_STEP;
   wire logic [PM_AW-1:0] next_pc = pc + pc_step;

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   wire logic [31:0] rd_mux =
        hit_work ? {24'h00_0000, work}
      : hit_flag ? {26'h000_0000, flags}
      : hit_tlow ? {24'h00_0000, tbl_low}
      : hit_thi  ? {24'h00_0000, tbl_high}
      : hit_tres ? {24'h00_0000, tbl_res}
      : hit_pc   ? {22'h00_0000, pc}
      : hit_dadr ? {24'h00_0000, dm_ptr}
      : hit_ddat ? {24'h00_0000, dmem[dm_ptr]}
      : hit_padr ? {22'h00_0000, pm_ptr}
      : hit_pdat ? {16'h0000, pmem[pm_ptr]}
      : hit_stat ? {29'h0000_0000, stat}
      : WORD_ZERO;

   ////////////////////////////////////////////////////////////////////////////
   // apb answer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= WORD_ZERO;
         dummy   <= 1'b0;
      end
      else
      begin
         pready  <= access & ~hold;
         pslverr <= access & ~hold & ~mapped;
         prdata  <= (access & ~pwrite) ? rd_mux : WORD_ZERO;
         dummy   <= hold;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // architectural registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         work     <= BYTE_RST;
         flags    <= FLAGS_RST;
         tbl_low  <= BYTE_RST;
         tbl_high <= BYTE_RST;
         tbl_res  <= BYTE_RST;
         pc       <= PC_RST;
         dm_ptr   <= BYTE_RST;
         pm_ptr   <= PC_RST;
         stat     <= STAT_RST;
      end
      else if (exec_go)
      begin
         work          <= next_work;
         flags         <= next_flags;
         tbl_low       <= next_tbl_low;
         pc            <= next_pc;
         stat[S_SKIP]    <= skip;
         stat[S_SKIPCLS] <= skip_cls;
         stat[S_BADOP]   <= bad_op;
         if (tres_we)
            tbl_res <= pm_word[PM_W-1:DATA_W];
      end
      else if (wr)
      begin
         if (hit_work)
            work <= pwdata[DATA_W-1:0];
         if (hit_flag)
            flags <= pwdata[FLAG_W-1:0];
         if (hit_tlow)
            tbl_low <= pwdata[DATA_W-1:0];
         if (hit_thi)
            tbl_high <= pwdata[DATA_W-1:0];
         if (hit_dadr)
            dm_ptr <= pwdata[DM_AW-1:0];
         if (hit_padr)
            pm_ptr <= pwdata[PM_AW-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // memories
   always_ff @(posedge pclk)
   begin
      if (exec_go & dm_we)
         dmem[m_addr] <= dm_wdata;
      else if (wr & hit_ddat)
         dmem[dm_ptr] <= pwdata[DATA_W-1:0];
      if (wr & hit_pdat)
         pmem[pm_ptr] <= pwdata[PM_W-1:0];
   end

endmodule : msst_exec

// >>> rtl/msst_pkg.sv
package msst_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int DATA_W    = 8;
   localparam int PM_W      = 16;
   localparam int PAGE_BITS = 2;
   localparam int PM_AW     = 10;
   localparam int DM_AW     = 8;
   localparam int FLAG_W    = 6;
   localparam int OP_W      = 5;
   localparam int BIT_W     = 3;
   localparam int STAT_W    = 3;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] OFS_CMD   = 8'h00;
   localparam logic [7:0] OFS_WORK  = 8'h04;
   localparam logic [7:0] OFS_FLAGS = 8'h08;
   localparam logic [7:0] OFS_TLOW  = 8'h0c;
   localparam logic [7:0] OFS_THIGH = 8'h10;
   localparam logic [7:0] OFS_TRES  = 8'h14;
   localparam logic [7:0] OFS_PC    = 8'h18;
   localparam logic [7:0] OFS_DADDR = 8'h1c;
   localparam logic [7:0] OFS_DDATA = 8'h20;
   localparam logic [7:0] OFS_PADDR = 8'h24;
   localparam logic [7:0] OFS_PDATA = 8'h28;
   localparam logic [7:0] OFS_STAT  = 8'h2c;

   ////////////////////////////////////////////////////////////////////////////
   // command word fields (lsb positions)
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_BIT_LSB  = 5;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_IMM_LSB  = 16;

   // flag bit positions
   localparam int F_CARRY = 0;
   localparam int F_HALF  = 1;
   localparam int F_ZERO  = 2;
   localparam int F_WRAP  = 3;
   localparam int F_SIGN  = 4;
   localparam int F_CZERO = 5;

   // status bit positions
   localparam int S_SKIP    = 0;
   localparam int S_SKIPCLS = 1;
   localparam int S_BADOP   = 2;

   ////////////////////////////////////////////////////////////////////////////
   // reset values and constants
   localparam logic [DATA_W-1:0]    BYTE_RST  = 8'h00;
   localparam logic [FLAG_W-1:0]    FLAGS_RST = 6'h00;
   localparam logic [PM_AW-1:0]     PC_RST    = 10'h000;
   localparam logic [STAT_W-1:0]    STAT_RST  = 3'h0;
   localparam logic [31:0]          WORD_ZERO = 32'h0000_0000;
   localparam logic [DATA_W-1:0]    BYTE_ONES = 8'hff;
   localparam logic [DATA_W-1:0]    BYTE_ONE  = 8'h01;
   localparam logic [PAGE_BITS-1:0] LAST_PAGE = 2'h3;
   localparam logic [PM_AW-1:0]     PC_STEP   = 10'h001;
   localparam logic [PM_AW-1:0]     PC_SKIP   = 10'h002;

   ////////////////////////////////////////////////////////////////////////////
   // instruction codes, numbered in order from zero
   typedef enum logic [OP_W-1:0] {
      OP_NOP,
      OP_MINUS_BORROW_MEM,
      OP_MINUS_BORROW_IMM,
      OP_MINUS_BORROW_TO_MEMORY,
      OP_MINUS_MEM,
      OP_MINUS_IMM,
      OP_MINUS_TO_MEMORY,
      OP_DECREMENT_SKIP_ON_ZERO,
      OP_DECREMENT_SKIP_TO_WORKING,
      OP_INCREMENT_SKIP_ON_ZERO,
      OP_INCREMENT_SKIP_TO_WORKING,
      OP_SET_BYTE,
      OP_SET_BIT,
      OP_SKIP_IF_NONZERO_BIT,
      OP_SKIP_IF_NONZERO,
      OP_SKIP_IF_ZERO_BIT,
      OP_SKIP_IF_ZERO,
      OP_COPY_AND_SKIP_ZERO,
      OP_NIBBLE_EXCHANGE,
      OP_NIBBLE_EXCHANGE_TO_WORKING,
      OP_PAGE_TABLE_READ,
      OP_LAST_PAGE_TABLE_READ,
      OP_PREINCREMENT_TABLE_READ,
      OP_PREINCREMENT_LAST_PAGE_READ,
      OP_XOR_MEM,
      OP_XOR_IMM,
      OP_EXCLUSIVE_OR_TO_MEMORY
   } msst_op_t;

   ////////////////////////////////////////////////////////////////////////////
   // a - b - borrow with flags; returns {flags, result}
   function automatic logic [FLAG_W+DATA_W-1:0] msst_sub(
      input logic [DATA_W-1:0] a,
      input logic [DATA_W-1:0] b,
      input logic              cin,
      input logic              cz_old,
      input logic              chain
   );
      logic [DATA_W:0]   s;
      logic [4:0]        h;
      logic [DATA_W-1:0] r;
      logic [FLAG_W-1:0] f;
      s = {1'b0, a} + {1'b0, ~b} + {{DATA_W{1'b0}}, cin};
      h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
      r = s[DATA_W-1:0];
      f = FLAGS_RST;
      f[F_CARRY] = s[DATA_W];
      f[F_HALF]  = h[4];
      f[F_ZERO]  = (r == BYTE_RST);
      f[F_WRAP]  = (a[DATA_W-1] ^ b[DATA_W-1]) & (r[DATA_W-1] ^ a[DATA_W-1]);
      f[F_SIGN]  = f[F_WRAP] ^ r[DATA_W-1];
      f[F_CZERO] = chain ? (f[F_ZERO] & cz_old) : f[F_ZERO];
      return {f, r};
   endfunction : msst_sub

endpackage : msst_pkg

// >>> testbench/msst_properties.sv
`timescale 1ns/1ps
module msst_properties
   import msst_pkg::*;
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   wire logic [4:0] op   = pwdata[4:0];
   wire logic       cmd  = pwrite && paddr == OFS_CMD;
   wire logic       skp  = cmd && op inside {[7:10], [13:17]};
   wire logic       fast = !(cmd && op inside {[7:17]});
   wire logic       bad  = paddr > OFS_STAT || paddr[1:0] != 2'h0;
   wire logic       rdw  = pready && !pwrite;

   sequence first_acc;
      psel && penable && $rose(penable);
   endsequence
   sequence one_wait;
      !pready ##1 pready;
   endsequence

   a_skip_two_cyc: assert property (first_acc ##0 skp |=> one_wait)
      else $error("skip op not two cycles");
   a_plain_one_cyc: assert property (first_acc ##0 fast |=> pready)
      else $error("plain access not zero wait");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_err_decode: assert property (pready |-> pslverr == bad)
      else $error("error flag wrong for address");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_idle_zero: assert property (!pready |-> prdata == WORD_ZERO)
      else $error("read data not zero when idle");
   a_err_zero: assert property (pslverr |-> prdata == WORD_ZERO)
      else $error("error with data");
   a_cmd_rd_zero: assert property (rdw && paddr == OFS_CMD |->
                                   prdata == WORD_ZERO)
      else $error("command reads nonzero");
   a_work_upper: assert property (rdw && paddr == OFS_WORK |->
                                  prdata[31:8] == 24'h00_0000)
      else $error("working upper bits set");
   a_pc_upper: assert property (rdw && paddr == OFS_PC |->
                                prdata[31:10] == 22'h00_0000)
      else $error("counter upper bits set");
endmodule : msst_properties

bind msst_exec msst_properties u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr)
);

// >>> testbench/msst_host.sv
`timescale 1ns/1ps
module msst_host
   import msst_pkg::*;
(
   // clock
   input  wire logic        pclk,
   // apb master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = WORD_ZERO;
   end

   // idle bus shows inverted last address and data
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask : xfer
endmodule : msst_host

// >>> testbench/mcu_subtract_skip_table_ops_bench.sv
`timescale 1ns/1ps
module mcu_subtract_skip_table_ops_bench
   import msst_pkg::*;
;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   int          err_count;
   int          samples_checked;

   msst_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   msst_host u_host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test

   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x)
      begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, g, x);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      u_host.xfer(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      u_host.xfer(1'b0, a, WORD_ZERO, r, e);
   endtask : rd

   task automatic chk(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      rd(a, r);
      cmp(r, x);
   endtask : chk

   task automatic poke(input logic [7:0] m, input logic [7:0] v);
      wr(OFS_DADDR, 32'(m));
      wr(OFS_DDATA, 32'(v));
   endtask : poke

   task automatic run(input logic [4:0] op, input logic [2:0] b,
                      input logic [7:0] m, input logic [7:0] imm);
      wr(OFS_CMD, {8'h00, imm, m, b, op});
   endtask : run

   function automatic logic [13:0] ref_sub(input logic [7:0] w, b,
                                            input logic ci, ch, czo);
      logic [8:0] s;
      logic [4:0] h;
      logic [5:0] f;
      s = {1'b0, w} + {1'b0, ~b} + 9'(ci);
      h = {1'b0, w[3:0]} + {1'b0, ~b[3:0]} + 5'(ci);
      f[F_CARRY] = s[8];
      f[F_HALF]  = h[4];
      f[F_ZERO]  = s[7:0] == 8'h00;
      f[F_WRAP]  = (w[7] ^ b[7]) & (s[7] ^ w[7]);
      f[F_SIGN]  = f[F_WRAP] ^ s[7];
      f[F_CZERO] = ch ? f[F_ZERO] & czo : f[F_ZERO];
      return {f, s[7:0]};
   endfunction : ref_sub

   function automatic logic [16:0] ref_skip(input logic [4:0] op,
      input logic [2:0] b, input logic [7:0] m, w);
      logic       sk;
      logic [7:0] nw;
      logic [7:0] nm;
      sk = 1'b0;
      nw = (op == 5'h11) ? m : w;
      nm = m;
      case (op)
         5'h07: nm = m - 8'h01;
         5'h08: nw = m - 8'h01;
         5'h09: nm = m + 8'h01;
         5'h0a: nw = m + 8'h01;
         5'h0b: nm = 8'hff;
         5'h0c: nm[b] = 1'b1;
         5'h0d: sk = m[b];
         5'h0e: sk = m != 8'h00;
         5'h0f: sk = !m[b];
         5'h10, 5'h11: sk = m == 8'h00;
         5'h12: nm = {m[3:0], m[7:4]};
         5'h13: nw = {m[3:0], m[7:4]};
         default: ;
      endcase
      if (op inside {[5'h07:5'h0a]})
         sk = (op[0] ? nm : nw) == 8'h00;
      return {sk, nw, nm};
   endfunction : ref_skip

   task automatic t_regs();
      logic [31:0] r;
      logic        e;
      for (int a = 4; a <= 44; a += 4)
         if (a != 32 && a != 40)
            chk(8'(a), WORD_ZERO);
      u_host.xfer(1'b0, 8'h30, WORD_ZERO, r, e);
      cmp(32'(e), 32'h0000_0001);
      chk(OFS_CMD, WORD_ZERO);
      run(5'h1b, 3'h0, 8'h00, 8'h00);
      chk(OFS_PC, 32'h0000_0001);
      chk(OFS_STAT, 32'h0000_0004);
      run(5'h00, 3'h0, 8'h00, 8'h00);
      chk(OFS_PC, 32'h0000_0002);
      chk(OFS_STAT, WORD_ZERO);
   endtask : t_regs

   task automatic t_sub();
      logic [7:0]  wv [3];
      logic [7:0]  bv [3];
      logic [13:0] e;
      logic [5:0]  f0;
      logic        bor;
      logic [31:0] fr;
      wv = '{8'h10, 8'h80, 8'h05};
      bv = '{8'h20, 8'h01, 8'h05};
      for (int k = 0; k < 3; k++)
         for (int op = 1; op <= 6; op++)
         begin
            bor = op <= 3;
            f0 = FLAGS_RST;
            f0[F_CARRY] = k != 0;
            f0[F_CZERO] = k != 2;
            e = ref_sub(wv[k], bv[k], bor ? f0[F_CARRY] : 1'b1, bor,
                        f0[F_CZERO]);
            wr(OFS_WORK, 32'(wv[k]));
            wr(OFS_FLAGS, 32'(f0));
            poke(8'h30, bv[k]);
            run(5'(op), 3'h0, 8'h30, bv[k]);
            if (op == 3 || op == 6)
            begin
               chk(OFS_DDATA, 32'(e[7:0]));
               chk(OFS_WORK, 32'(wv[k]));
            end
            else
               chk(OFS_WORK, 32'(e[7:0]));
            rd(OFS_FLAGS, fr);
            cmp(fr, 32'(e[13:8]));
            cmp(32'(fr[F_CARRY]), 32'(9'(wv[k]) >= 9'(bv[k])
                + 9'(bor & ~f0[F_CARRY])));
         end
   endtask : t_sub

   task automatic t_skip();
      logic [15:0] tb [21];
      logic [16:0] e;
      logic [31:0] p0;
      logic [31:0] p1;
      tb = '{16'h0701, 16'h0705, 16'h0801, 16'h09ff, 16'h0900, 16'h0aff,
             16'h0a10, 16'h0b00, 16'hac00, 16'h6d08, 16'h6df7, 16'h0e00,
             16'h0e01, 16'h0ffe, 16'h0f01, 16'h1000, 16'h1002, 16'h1100,
             16'h1103, 16'h123c, 16'h13a5};
      foreach (tb[i])
      begin
         wr(OFS_WORK, 32'h0000_0077);
         wr(OFS_FLAGS, 32'h0000_0015);
         poke(8'h41, tb[i][7:0]);
         rd(OFS_PC, p0);
         run(tb[i][12:8], tb[i][15:13], 8'h41, 8'h00);
         e = ref_skip(tb[i][12:8], tb[i][15:13], tb[i][7:0], 8'h77);
         rd(OFS_PC, p1);
         cmp(p1, (p0 + (e[16] ? 2 : 1)) & 32'h0000_03ff);
         rd(OFS_STAT, p1);
         cmp(p1 & 32'h0000_0001, 32'(e[16]));
         chk(OFS_WORK, 32'(e[15:8]));
         chk(OFS_DDATA, 32'(e[7:0]));
         chk(OFS_FLAGS, 32'h0000_0015);
      end
   endtask : t_skip

   task automatic t_tbl();
      logic [15:0] pw;
      wr(OFS_PADDR, 32'h0000_0110);
      wr(OFS_PDATA, 32'h0000_abcd);
      wr(OFS_PADDR, 32'h0000_0310);
      wr(OFS_PDATA, 32'h0000_1234);
      wr(OFS_THIGH, 32'h0000_0001);
      wr(OFS_FLAGS, 32'h0000_002a);
      for (int op = 20; op <= 23; op++)
      begin
         wr(OFS_TLOW, op >= 22 ? 32'h0000_000f : 32'h0000_0010);
         run(5'(op), 3'h0, 8'h50, 8'h00);
         pw = op[0] ? 16'h1234 : 16'habcd;
         wr(OFS_DADDR, 32'h0000_0050);
         chk(OFS_DDATA, 32'(pw[7:0]));
         chk(OFS_TRES, 32'(pw[15:8]));
         chk(OFS_TLOW, 32'h0000_0010);
      end
      chk(OFS_FLAGS, 32'h0000_002a);
   endtask : t_tbl

   task automatic t_xor();
      logic [7:0] b;
      logic [7:0] r;
      for (int k = 0; k < 2; k++)
         for (int op = 24; op <= 26; op++)
         begin
            b = k ? 8'h0f : 8'h5a;
            r = b ^ 8'h5a;
            wr(OFS_WORK, 32'h0000_005a);
            wr(OFS_FLAGS, k ? 32'h0000_003f : 32'h0000_003b);
            poke(8'h60, b);
            run(5'(op), 3'h0, 8'h60, b);
            chk(op == 26 ? OFS_DDATA : OFS_WORK, 32'(r));
            chk(OFS_FLAGS, r == 8'h00 ? 32'h0000_003f
                                      : 32'h0000_003b);
         end
   endtask : t_xor

   initial
   begin
      pclk = 1'b0;
      forever
         #2.5 pclk = ~pclk;
   end

   initial
   begin
      #200000;
      err_count++;
      stop_test();
   end

   initial
   begin
      err_count = 0;
      samples_checked = 0;
      presetn = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      $display("done regs");
      t_sub();
      $display("done sub");
      t_skip();
      $display("done skip");
      t_tbl();
      $display("done table");
      t_xor();
      $display("done xor");
      stop_test();
   end
endmodule : mcu_subtract_skip_table_ops_bench
